// File: sal_top.sv
// security alarm collection, access supervision, mpu and test-mode lock
// assumes AHB-Lite single word transfers, nvm straps stable at reset release
//
// Overview of operation
// - out-of-range failures reset chip by default
// - every detector event latched in status
// - software picks reset or flag per detector
// - seven detector inputs accepted
// - tamper raises reset or fast interrupt
// - invalid address raises fast interrupt
// - forbidden eeprom code fetch raises fast interrupt
// - security registers need privileged access, except user reads of event and access status
// - all registers take defaults at reset
// - mpu regions restrict user accesses
// - test mode only after correct password
// - normal mode final, test commands rejected
// - trace data writable once in test
// - functional test and checksum test-only
// - external reset and clock pads filtered
// - detection cannot be disabled by software
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sal_top
    import sal_pkg::*;
#(
    parameter int          NREG      = 4,
    parameter logic [15:0] ADDR_TOP  = 16'hBFFF,
    parameter logic [15:0] EE_LO     = 16'h4000,
    parameter logic [15:0] EE_HI     = 16'h7FFF,
    parameter logic [31:0] TEST_PW   = 32'h1234_5678, // arbitrary value
    parameter logic [31:0] CKSUM_REF = 32'h0000_0000
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [3:0]   hprot,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // detectors and pads
    input  wire logic [6:0]   detRaw,
    input  wire logic         extRstPin,
    input  wire logic         clkPadPin,
    output logic              clkPadFilt,
    // processor access check
    input  wire sal_cpu_acc_t cpuAcc,
    output logic              cpuDeny,
    output logic              fastIrq,
    output logic              chipReset,
    // nvm and test protocol
    input  wire logic         nvmNormal,
    input  wire logic         nvmTraceDone,
    input  wire logic         testPwStrobe,
    input  wire logic [31:0]  testPw,
    output logic              testModeActive,
    output logic              nvmBurnNormal,
    output logic              traceProg,
    output logic [31:0]       traceData
);
    logic                rstMeta_q;
    logic                rstSync_b;
    logic [6:0]          detLive;
    logic                extRstFilt;
    logic                dpWr_q;
    logic                dpPriv_q;
    logic [7:0]          dpAddr_q;
    logic [31:0]         hrdata_q;
    logic                hready_q;
    logic [6:0]          evt_q;
    logic [6:0]          react_q;
    logic [ACC_W-1:0]    acc_q;
    logic [MPU_BITS-1:0] mpu_q [NREG];
    sal_lc_t             lc_q;
    sal_lc_t             lc_d;
    logic                strapDone_q;
    logic                trcDone_q;
    logic [31:0]         trace_q;
    logic [31:0]         cksum_q;
    logic                burn_q;
    logic                prog_q;
    logic                deny_q;
    logic                irq_q;
    logic                rst_q;
    logic                testAct_q;

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_b <= rstMeta_q;
        end
    end

    // detector inputs, always live whatever the configuration
    sal_pin_filter #(.STABLE(1)) uDet [NDET-1:0] (
        .clock     (clock),
        .rstSync_b (rstSync_b),
        .pinIn     (detRaw),
        .filtOut   (detLive)
    );
    sal_pin_filter #(.STABLE(FILT_CYC)) uRstFilt (
        .clock     (clock),
        .rstSync_b (rstSync_b),
        .pinIn     (extRstPin),
        .filtOut   (extRstFilt)
    );
    sal_pin_filter #(.STABLE(FILT_CYC)) uClkFilt (
        .clock     (clock),
        .rstSync_b (rstSync_b),
        .pinIn     (clkPadPin),
        .filtOut   (clkPadFilt)
    );

    function automatic logic mpuAllow(input logic [15:0] a, input int perm);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < NREG; i++) begin
            if (a[15:8] >= mpu_q[i][MPU_LO+:8] && a[15:8] <= mpu_q[i][MPU_HI+:8]
                && mpu_q[i][perm]) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // bus decode
    wire        addrTake = hsel && hready && htrans[1];
    wire        rdTake   = addrTake && !hwrite;
    wire [7:0]  aAddr    = haddr[7:0];
    wire        aPriv    = hprot[1];
    wire        aMpu     = aAddr >= A_MPU0 && aAddr < A_MPU0 + 8'(4 * NREG);
    wire        aUserOk  = aAddr == A_EVT || aAddr == A_ACC;
    wire        aMapped  = aUserOk || aMpu || aAddr == A_REACT || aAddr == A_MODE
                           || aAddr == A_TRACE || aAddr == A_CKSUM;
    wire        rdDenied = rdTake && aMapped && !aUserOk && !aPriv;
    wire        inTest   = lc_q == LC_TEST;
    wire [31:0] modeWord = {28'h0, inTest && cksum_q == CKSUM_REF, trcDone_q,
                            lc_q == LC_NORMAL, inTest};
    wire [31:0] mpuWord  = 32'(mpu_q[aAddr[3:2]]);
    wire [31:0] rdData   = rdDenied              ? 32'h0000_0000 :
                           aAddr == A_EVT        ? 32'(evt_q) :
                           aAddr == A_REACT      ? 32'(react_q) :
                           aAddr == A_ACC        ? 32'(acc_q) :
                           aAddr == A_MODE       ? modeWord :
                           aAddr == A_TRACE      ? trace_q :
                           aAddr == A_CKSUM      ? (inTest ? cksum_q : 32'h0) :
                           aMpu                  ? mpuWord : 32'h0000_0000;

    // data-phase write strobes, privileged only
    wire        wrOk     = dpWr_q && dpPriv_q;
    wire        wrDenied = dpWr_q && !dpPriv_q;
    wire        wrEvt    = wrOk && dpAddr_q == A_EVT;
    wire        wrReact  = wrOk && dpAddr_q == A_REACT;
    wire        wrAcc    = wrOk && dpAddr_q == A_ACC;
    wire        wrMode   = wrOk && dpAddr_q == A_MODE;
    wire        wrTrace  = wrOk && dpAddr_q == A_TRACE && inTest && !trcDone_q;
    wire        wrCksum  = wrOk && dpAddr_q == A_CKSUM && inTest;
    wire        wrMpu    = wrOk && dpAddr_q >= A_MPU0 && dpAddr_q < A_MPU0 + 8'(4 * NREG);

    // detector events: set wins over clear
    wire [6:0]  evtClr   = wrEvt ? hwdata[6:0] : 7'h00;
    wire [6:0]  evt_d    = (evt_q & ~evtClr) | detLive;
    wire [6:0]  rstCause = detLive & ~react_q;
    wire        tamperIrq = |(evt_q & react_q & TAMPER_MSK);

    // processor access supervision
    wire        invAddr  = cpuAcc.valid && cpuAcc.addr > ADDR_TOP;
    wire        eeHit    = cpuAcc.addr >= EE_LO && cpuAcc.addr <= EE_HI;
    wire        exeViol  = cpuAcc.valid && cpuAcc.fetch && eeHit && !cpuAcc.priv
                           && !mpuAllow(cpuAcc.addr, MPU_X);
    wire        mpuViol  = cpuAcc.valid && !cpuAcc.priv && !cpuAcc.fetch && !invAddr
                           && !mpuAllow(cpuAcc.addr, cpuAcc.write ? MPU_W : MPU_R);

    // life cycle: strap first, password, then one-way switch
    wire        pwGood   = testPwStrobe && testPw == TEST_PW;
    wire        toNormal = wrMode && inTest && hwdata == MODE_KEY;
    wire        authFail = testPwStrobe && strapDone_q && lc_q != LC_TEST && !pwGood
                           || testPwStrobe && lc_q == LC_NORMAL;
    wire [ACC_W-1:0] accSet = {authFail, wrDenied || rdDenied, mpuViol, exeViol, invAddr};
    wire [ACC_W-1:0] accClr = wrAcc ? hwdata[ACC_W-1:0] : '0;
    wire [ACC_W-1:0] acc_d  = (acc_q & ~accClr) | accSet;

    always_comb begin
        lc_d = lc_q;
        case (lc_q)
            LC_LOCKED: begin
                if (!strapDone_q) begin
                    if (nvmNormal) begin
                        lc_d = LC_NORMAL;
                    end
                end else if (pwGood) begin
                    lc_d = LC_TEST;
                end
            end
            LC_TEST: begin
                if (toNormal) begin
                    lc_d = LC_NORMAL;
                end
            end
            LC_NORMAL: lc_d = LC_NORMAL;
            default:   lc_d = LC_NORMAL;
        endcase
    end

    // bus pipeline
    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            dpWr_q   <= 1'b0;
            dpPriv_q <= 1'b0;
            dpAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b0;
        end else begin
            dpWr_q   <= addrTake && hwrite && aMapped;
            dpPriv_q <= aPriv;
            dpAddr_q <= aAddr;
            hrdata_q <= rdTake ? rdData : 32'h0000_0000;
            hready_q <= 1'b1;
        end
    end

    // status, configuration and life-cycle state
    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            evt_q       <= 7'h00;
            react_q     <= REACT_RST;
            acc_q       <= '0;
            lc_q        <= LC_LOCKED;
            strapDone_q <= 1'b0;
            trcDone_q   <= 1'b0;
            trace_q     <= 32'h0000_0000;
            cksum_q     <= 32'h0000_0000;
            testAct_q   <= 1'b0;
        end else begin
            evt_q       <= evt_d;
            react_q     <= wrReact ? hwdata[6:0] : react_q;
            acc_q       <= acc_d;
            lc_q        <= lc_d;
            strapDone_q <= 1'b1;
            trcDone_q   <= (!strapDone_q && nvmTraceDone) || wrTrace || trcDone_q;
            trace_q     <= wrTrace ? hwdata : trace_q;
            cksum_q     <= wrCksum ? cksum_q + hwdata : cksum_q;
            testAct_q   <= lc_d == LC_TEST;
        end
    end

    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            for (int i = 0; i < NREG; i++) begin
                mpu_q[i] <= MPU_RST;
            end
        end else if (wrMpu) begin
            mpu_q[dpAddr_q[3:2]] <= hwdata[MPU_BITS-1:0];
        end
    end

    // reactions and nvm strobes
    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            rst_q  <= 1'b0;
            irq_q  <= 1'b0;
            deny_q <= 1'b0;
            burn_q <= 1'b0;
            prog_q <= 1'b0;
        end else begin
            rst_q  <= |rstCause || extRstFilt;
            irq_q  <= |acc_d[ACC_MPU:ACC_INV] || tamperIrq;
            deny_q <= invAddr || exeViol || mpuViol;
            burn_q <= toNormal;
            prog_q <= wrTrace;
        end
    end

    assign hreadyout      = hready_q;
    assign hresp          = 1'b0;
    assign hrdata         = hrdata_q;
    assign cpuDeny        = deny_q;
    assign fastIrq        = irq_q;
    assign chipReset      = rst_q;
    assign testModeActive = testAct_q;
    assign nvmBurnNormal  = burn_q;
    assign traceProg      = prog_q;
    assign traceData      = trace_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync_b);

    a_det_capture: assert property (|detLive |=> (evt_q & $past(detLive)) == $past(detLive))
        else $error("detector event not latched");
    a_evt_sticky: assert property (|(evt_q & ~evtClr) |=>
        (evt_q & $past(evt_q & ~evtClr)) == $past(evt_q & ~evtClr))
        else $error("event flag lost without clear");
    a_reset_react: assert property (|rstCause |=> chipReset)
        else $error("reset reaction missing");
    a_flag_react: assert property (!(|rstCause) && !extRstFilt |=> !chipReset)
        else $error("reset raised in flag mode");
    a_inv_irq: assert property (invAddr |=> fastIrq && acc_q[ACC_INV] && cpuDeny)
        else $error("invalid address not trapped");
    a_exe_irq: assert property (exeViol |=> fastIrq ##1 acc_q[ACC_EXE])
        else $error("eeprom fetch not trapped");
    a_priv_write: assert property (wrDenied |=> $stable(react_q) && acc_q[ACC_REG])
        else $error("user write not refused");
    a_mpu_user: assert property (mpuViol |=> cpuDeny && fastIrq)
        else $error("user access outside regions passed");
    a_test_entry: assert property ($rose(testModeActive) |-> $past(pwGood && strapDone_q))
        else $error("test mode without password");
    a_normal_final: assert property (lc_q == LC_NORMAL |=> lc_q == LC_NORMAL [*4])
        else $error("left normal mode");
    a_trace_once: assert property (traceProg |-> trcDone_q && !$past(trcDone_q)
        && $past(inTest)) else $error("trace written twice");
    a_reset_vals: assert property ($rose(rstSync_b) |-> evt_q == 7'h00
        && react_q == REACT_RST && acc_q == '0) else $error("register default missing");
    a_auth_normal: assert property (testPwStrobe && lc_q == LC_NORMAL |=> acc_q[ACC_AUTH]
        && lc_q == LC_NORMAL) else $error("test password taken in normal mode");
    a_cksum_hidden: assert property (rdTake && aAddr == A_CKSUM && !inTest
        |=> hrdata == 32'h0000_0000) else $error("checksum readable outside test");
    a_burn_once: assert property (nvmBurnNormal |-> $past(inTest) && lc_q == LC_NORMAL)
        else $error("normal mode burnt outside test");

    c_test_to_normal: cover property (lc_q == LC_TEST ##[1:50] lc_q == LC_NORMAL);
    c_det_reset: cover property ($rose(chipReset));
    c_irq: cover property ($rose(fastIrq));
    c_flag_only: cover property (|(evt_q & react_q) && !chipReset);
    c_wrong_pw: cover property (testPwStrobe && !pwGood);
endmodule

// File: sal_pkg.sv
// constants, types and register map of the security alarm and test lock
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register port
package sal_pkg;
    localparam int          CLK_MHZ    = 100;
    localparam int          NDET       = 7;
    // detector bit positions
    localparam int          DET_FREQ   = 0;
    localparam int          DET_VOLT   = 1;
    localparam int          DET_TEMP   = 2;
    localparam int          DET_LIGHT  = 3;
    localparam int          DET_INSUL  = 4;
    localparam int          DET_SHIELD = 5;
    localparam int          DET_GLITCH = 6;
    localparam logic [6:0]  TAMPER_MSK = 7'h38;
    // register byte offsets
    localparam logic [7:0]  A_EVT      = 8'h00;
    localparam logic [7:0]  A_REACT    = 8'h04;
    localparam logic [7:0]  A_ACC      = 8'h08;
    localparam logic [7:0]  A_MODE     = 8'h0C;
    localparam logic [7:0]  A_TRACE    = 8'h10;
    localparam logic [7:0]  A_CKSUM    = 8'h14;
    localparam logic [7:0]  A_MPU0     = 8'h20;
    // access status bits
    localparam int          ACC_INV    = 0;
    localparam int          ACC_EXE    = 1;
    localparam int          ACC_MPU    = 2;
    localparam int          ACC_REG    = 3;
    localparam int          ACC_AUTH   = 4;
    localparam int          ACC_W      = 5;
    // mode register bits
    localparam int          MODE_TEST  = 0;
    localparam int          MODE_NORM  = 1;
    localparam int          MODE_TRC   = 2;
    localparam int          MODE_CKOK  = 3;
    localparam logic [31:0] MODE_KEY   = 32'h0000_00A5;
    // mpu region fields
    localparam int          MPU_LO     = 0;
    localparam int          MPU_HI     = 8;
    localparam int          MPU_R      = 16;
    localparam int          MPU_W      = 17;
    localparam int          MPU_X      = 18;
    localparam int          MPU_BITS   = 19;
    // reset values
    localparam logic [6:0]  REACT_RST  = 7'h00;
    localparam logic [18:0] MPU_RST    = 19'h0_0000;
    // filter time, least, in ns
    localparam int          FILT_NS    = 50;
    localparam int          FILT_CYC   = (FILT_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic        valid;
        logic        priv;
        logic        write;
        logic        fetch;
        logic [15:0] addr;
    } sal_cpu_acc_t;

    typedef enum logic [2:0] {
        LC_LOCKED = 3'b001,
        LC_TEST   = 3'b010,
        LC_NORMAL = 3'b100
    } sal_lc_t;
endpackage

// File: sal_pin_filter.sv
// three-stage synchroniser with a stability filter for one pad level
// assumes the reset given is already synchronous to clock
`timescale 1ns/1ps
module sal_pin_filter
    import sal_pkg::*;
#(
    parameter int STABLE = 1
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstSync_b,
    // pad and filtered level
    input  wire logic pinIn,
    output logic      filtOut
);
    localparam int CW = $clog2(STABLE + 1);

    logic          s1_q;
    logic          s2_q;
    logic          s3_q;
    logic          out_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          agree;
    logic          differ;
    logic          take;

    // change counts only when stages two and three agree
    assign agree   = (s2_q == s3_q);
    assign differ  = agree && (s3_q != out_q);
    assign take    = differ && (cnt_q == CW'(STABLE - 1));
    assign cnt_d   = (differ && !take) ? cnt_q + CW'(1) : '0;
    assign filtOut = out_q;

    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            out_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            s1_q  <= pinIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= take ? s3_q : out_q;
            cnt_q <= cnt_d;
        end
    end
endmodule

// File: sal_ahb_master.sv
// AHB-Lite master standing in for the core's software on the register port
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
module sal_ahb_master (
    // clock and bus ready
    input  wire logic        clock,
    input  wire logic        hready,
    // request
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [3:0]       hprot,
    output logic [31:0]      hwdata,
    // high during a read data phase
    output logic             rdPh
);
    initial begin
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hprot = 4'h3;
        hwdata = 32'h0;
        rdPh = 1'b0;
    end

    // address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic pv);
        @(posedge clock);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hprot <= {2'h0, pv, 1'b1};
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        rdPh <= !w;
        do @(posedge clock); while (hready !== 1'b1);
        rdPh <= 1'b0;
        hwdata <= ~hwdata;
    endtask
endmodule

// File: sal_top_tb.sv
// self-checking bench of the security alarm and test lock
// assumes the design's zero-wait register port and the package constants
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module sal_top_tb;
    import sal_pkg::*;
    localparam logic [31:0] PW = 32'h1234_5678; // arbitrary value
    logic         clock, rst_b, hreadyout, hresp, rdPh, clkPadFilt;
    logic         cpuDeny, fastIrq, chipReset, extRstPin, clkPadPin;
    logic         nvmNormal, testPwStrobe, testModeActive, nvmBurnNormal, traceProg;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [3:0]   hprot;
    logic [31:0]  haddr, hwdata, hrdata, testPw, traceData, seed, d, s1, s2;
    logic [6:0]   detRaw;
    logic [63:0]  e;
    logic [63:0]  expQ[$];
    sal_cpu_acc_t cpuAcc;
    int           n_checks, n_mismatch, nProg, nBurn, cycles;

    sal_ahb_master m (.clock(clock), .hready(hreadyout), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hprot(hprot), .hwdata(hwdata), .rdPh(rdPh));

    sal_top #(.TEST_PW(PW)) dut (.clock(clock), .rst_b(rst_b), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hprot(hprot),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .detRaw(detRaw), .extRstPin(extRstPin), .clkPadPin(clkPadPin),
        .clkPadFilt(clkPadFilt), .cpuAcc(cpuAcc), .cpuDeny(cpuDeny), .fastIrq(fastIrq),
        .chipReset(chipReset), .nvmNormal(nvmNormal), .nvmTraceDone(1'b0),
        .testPwStrobe(testPwStrobe), .testPw(testPw), .testModeActive(testModeActive),
        .nvmBurnNormal(nvmBurnNormal), .traceProg(traceProg), .traceData(traceData));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // read data compared under a mask, oldest note first
    always @(posedge clock) begin
        cycles++;
        if (traceProg === 1'b1) nProg++;
        if (nvmBurnNormal === 1'b1) nBurn++;
        if (rdPh === 1'b1 && hreadyout === 1'b1) begin
            e = expQ.pop_front();
            `CHK(hrdata & e[63:32], e[31:0])
            `CHK(hresp, 1'b0)
        end
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic pv);
        m.xfer(1'b1, a, v, pv);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] k,
                      input logic pv = 1'b1);
        expQ.push_back({k, v & k});
        m.xfer(1'b0, a, 32'h0, pv);
    endtask
    task automatic det(input logic [6:0] v);
        @(posedge clock);
        detRaw <= v;
        cyc(6);
    endtask
    task automatic pw(input logic [31:0] v);
        @(posedge clock);
        testPwStrobe <= 1'b1;
        testPw <= v;
        @(posedge clock);
        testPwStrobe <= 1'b0;
        testPw <= xs();
        cyc(2);
    endtask
    // one core access, then deny, interrupt and status bit
    task automatic core(input logic pv, w, f, input logic [15:0] a, input logic dn,
                        input logic [31:0] k);
        @(posedge clock);
        cpuAcc <= {1'b1, pv, w, f, a};
        @(posedge clock);
        cpuAcc <= '0;
        #1;
        `CHK(cpuDeny, dn)
        cyc(1);
        `CHK(fastIrq, dn)
        rd(A_ACC, dn ? k : 32'h0, k);
        wr(A_ACC, 32'h1F, 1'b1);
        cyc(2);
    endtask
    task automatic ready();
        for (int k = 0; k < 50 && hreadyout !== 1'b1; k++) @(posedge clock);
        cyc(4);
    endtask

    initial begin
        seed = 32'd12;
        rst_b = 1'b0;
        detRaw = '0;
        extRstPin = 1'b0;
        clkPadPin = 1'b0;
        cpuAcc = '0;
        nvmNormal = 1'b0;
        testPwStrobe = 1'b0;
        testPw = '0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        ready();
        rd(A_REACT, {25'h0, REACT_RST}, 32'h7F);
        rd(A_MPU0, 32'h0, 32'h7_FFFF);
        rd(A_MODE, 32'h0, 32'h3);
        // default reaction is reset
        det(7'h02);
        `CHK(chipReset, 1'b1)
        det(7'h00);
        `CHK(chipReset, 1'b0)
        rd(A_EVT, 32'h2, 32'h7F);
        wr(A_EVT, 32'h2, 1'b1);
        rd(A_EVT, 32'h0, 32'h7F);
        // flag reaction on every detector
        wr(A_REACT, 32'h7F, 1'b1);
        for (int i = 0; i < NDET; i++) begin
            det(7'(1 << i));
            `CHK(chipReset, 1'b0)
            det(7'h00);
            rd(A_EVT, (32'h2 << i) - 32'h1, 32'h7F);
        end
        `CHK(fastIrq, 1'b1)
        wr(A_EVT, 32'h7F, 1'b1);
        cyc(3);
        `CHK(fastIrq, 1'b0)
        // user-mode register access refused, unmapped reads zero
        wr(A_REACT, 32'h0, 1'b0);
        rd(A_REACT, 32'h7F, 32'h7F);
        rd(A_REACT, 32'h0, 32'hFFFF_FFFF, 1'b0);
        rd(A_ACC, 32'h8, 32'h8);
        rd(8'h3C, 32'h0, 32'hFFFF_FFFF);
        wr(A_ACC, 32'h1F, 1'b1);
        // mpu region 0 covers page 80 for reading
        wr(A_MPU0, 32'h0001_8080, 1'b1);
        core(1'b0, 1'b0, 1'b0, 16'h8010, 1'b0, 32'h4);
        core(1'b0, 1'b1, 1'b0, 16'h8010, 1'b1, 32'h4);
        core(1'b1, 1'b1, 1'b0, 16'h9000, 1'b0, 32'h4);
        core(1'b0, 1'b0, 1'b1, 16'h4100, 1'b1, 32'h2);
        core(1'b0, 1'b0, 1'b0, 16'hC000, 1'b1, 32'h1);
        // test mode entry
        pw(PW ^ 32'h0000_0100);
        `CHK(testModeActive, 1'b0)
        rd(A_ACC, 32'h10, 32'h10);
        wr(A_ACC, 32'h1F, 1'b1);
        pw(PW);
        `CHK(testModeActive, 1'b1)
        d = xs();
        wr(A_TRACE, d, 1'b1);
        wr(A_TRACE, ~d, 1'b1);
        cyc(2);
        `CHK(nProg, 1)
        `CHK(traceData, d)
        wr(A_MODE, ~MODE_KEY, 1'b1);
        rd(A_MODE, 32'hD, 32'hF);
        s1 = xs();
        s2 = xs();
        wr(A_CKSUM, s1, 1'b1);
        wr(A_CKSUM, s2, 1'b1);
        rd(A_CKSUM, s1 + s2, 32'hFFFF_FFFF);
        // switch to normal mode, never back
        wr(A_MODE, MODE_KEY, 1'b1);
        cyc(2);
        `CHK(nBurn, 1)
        `CHK(testModeActive, 1'b0)
        rd(A_MODE, 32'h2, 32'h3);
        pw(PW);
        `CHK(testModeActive, 1'b0)
        rd(A_CKSUM, 32'h0, 32'hFFFF_FFFF);
        wr(A_TRACE, d, 1'b1);
        cyc(2);
        `CHK(nProg, 1)
        // pad filters: short glitch dropped, long level passed
        @(posedge clock);
        extRstPin <= 1'b1;
        repeat (2) @(posedge clock);
        extRstPin <= 1'b0;
        cyc(10);
        `CHK(chipReset, 1'b0)
        @(posedge clock);
        extRstPin <= 1'b1;
        clkPadPin <= 1'b1;
        cyc(12);
        `CHK(chipReset, 1'b1)
        `CHK(clkPadFilt, 1'b1)
        @(posedge clock);
        extRstPin <= 1'b0;
        cyc(12);
        `CHK(chipReset, 1'b0)
        // second reset with the normal strap burnt
        @(posedge clock);
        nvmNormal <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        ready();
        rd(A_MODE, 32'h2, 32'h3);
        pw(PW);
        `CHK(testModeActive, 1'b0)
        cyc(4);
        results();
    end
endmodule
